// ===== rtl/giw_pkg.sv
// Package with register map, source layout and field positions
package giw_pkg;

  // Source flag layout
  localparam int unsigned NUM_SRC   = 6;
  localparam int unsigned NUM_GRP   = 3;
  localparam int unsigned NUM_TM    = 2;
  localparam int unsigned SRC_EEP   = 0;
  localparam int unsigned SRC_LV    = 1;
  localparam int unsigned SRC_TM0   = 2;
  localparam int unsigned PC_W      = 13;
  localparam int unsigned STK_DEPTH = 8;
  localparam int unsigned STK_PTR_W = 4;

  // Group membership, one mask per group
  localparam logic [NUM_SRC-1:0] GRP_MEMBER [NUM_GRP] = '{
    6'h03,
    6'h0c,
    6'h30
  };

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_SRC_FL = 8'h04;
  localparam logic [7:0] OFF_SRC_EN = 8'h08;
  localparam logic [7:0] OFF_GRP_FL = 8'h0c;
  localparam logic [7:0] OFF_GRP_EN = 8'h10;
  localparam logic [7:0] OFF_STAT   = 8'h14;

  // Field positions
  localparam int unsigned CTRL_GIE_BIT   = 0;
  localparam int unsigned STAT_CLK_BIT   = 0;
  localparam int unsigned STAT_FULL_BIT  = 1;
  localparam int unsigned STAT_REQ_BIT   = 2;
  localparam int unsigned STAT_DEPTH_LSB = 4;

  // Reset values
  localparam logic                 RST_GIE     = 1'b0;
  localparam logic [NUM_SRC-1:0]   RST_SRC_FL  = 6'h00;
  localparam logic [NUM_SRC-1:0]   RST_SRC_EN  = 6'h00;
  localparam logic [NUM_GRP-1:0]   RST_GRP_FL  = 3'h0;
  localparam logic [NUM_GRP-1:0]   RST_GRP_EN  = 3'h0;

  // Clock mode option encodings
  localparam logic CLK_MODE_12MHZ = 1'b1;
  localparam logic CLK_MODE_6MHZ  = 1'b0;

endpackage

// ===== rtl/giw_pc_stack.sv
// Return address stack shared by calls and interrupt entry
`timescale 1ns/1ps
module giw_pc_stack (
  // Clock and reset
  input  wire logic                         i_core_clk,
  input  wire logic                         i_rst,
  // Push and pop
  input  wire logic                         i_push,
  input  wire logic                         i_pop,
  input  wire logic [giw_pkg::PC_W-1:0]     i_pc,
  // State
  output logic      [giw_pkg::PC_W-1:0]     o_top_pc,
  output logic                              o_full,
  output logic      [giw_pkg::STK_PTR_W-1:0] o_depth
);
  import giw_pkg::*;

  logic [PC_W-1:0]      mem [STK_DEPTH];
  logic [STK_PTR_W-1:0] ptr_r;
  logic [STK_PTR_W-1:0] ptr_nxt;
  logic                 do_push;
  logic                 do_pop;

  assign o_full  = (ptr_r == STK_PTR_W'(STK_DEPTH));
  assign o_depth = ptr_r;
  assign do_push = i_push && !o_full;
  assign do_pop  = i_pop && (ptr_r != '0) && !i_push;
  // Empty stack reads as address zero rather than a stale entry
  assign o_top_pc = (ptr_r == '0) ? '0 : mem[ptr_r[2:0] - 3'h1];

  always_comb begin
    ptr_nxt = ptr_r;
    if (do_push) begin
      ptr_nxt = ptr_r + 4'h1;
    end else if (do_pop) begin
      ptr_nxt = ptr_r - 4'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ptr_r <= '0;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  // Contents need no reset; the pointer guards every read
  always_ff @(posedge i_core_clk) begin
    if (do_push) begin
      mem[ptr_r[2:0]] <= i_pc;
    end
  end

endmodule

// ===== rtl/giw_irq_ctrl.sv
// Grouped interrupt controller with wake-up and return handling
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - EEPROM write-done pulse sets the EEPROM source flag.
// - Vector only when global, source and group enables set, stack not full.
// - Entry clears global enable and group flag; source flag stays.
// - Synchronised low-voltage report sets the low-voltage flag.
// - Each timer has comparator A and P flags with own enables.
// - Either timer match flag raises a request through its group.
// - Any flag rising from low to high wakes a sleeping core.
// - Flags stay set until serviced or cleared; enables never clear them.
// - Entry pushes only the program counter onto the stack.
// - Interrupt return sets global enable; plain return leaves it unchanged.
// - Clock mode option latched during reset, read-only to software.
// - A source flag rising sets its group flag.
module giw_irq_ctrl (
  // Clock and reset
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst,
  // Wishbone slave
  input  wire logic                          i_wb_cyc,
  input  wire logic                          i_wb_stb,
  input  wire logic                          i_wb_we,
  input  wire logic [7:0]                    i_wb_adr,
  input  wire logic [3:0]                    i_wb_sel,
  input  wire logic [31:0]                   i_wb_dat,
  output logic      [31:0]                   o_wb_dat,
  output logic                               o_wb_ack,
  // Event sources
  input  wire logic                          i_eeprom_write_done,
  input  wire logic                          i_low_voltage,
  input  wire logic [giw_pkg::NUM_TM-1:0]    i_tm_match_a,
  input  wire logic [giw_pkg::NUM_TM-1:0]    i_tm_match_p,
  input  wire logic                          i_cfg_clk_mode,
  // CPU core
  input  wire logic [giw_pkg::PC_W-1:0]      i_pc,
  input  wire logic                          i_irq_ack,
  input  wire logic                          i_call,
  input  wire logic                          i_ret,
  input  wire logic                          i_irq_return_instr,
  input  wire logic                          i_sleep,
  output logic                               o_irq_req,
  output logic      [1:0]                    o_irq_vec,
  output logic      [giw_pkg::PC_W-1:0]      o_ret_pc,
  output logic                               o_wake,
  output logic                               o_clk_mode
);
  import giw_pkg::*;

  localparam int unsigned NFL = NUM_SRC + NUM_GRP;

  logic                 gie_r, gie_nxt;
  logic [NUM_SRC-1:0]   src_flag_r, src_flag_nxt;
  logic [NUM_SRC-1:0]   src_en_r, src_en_nxt;
  logic [NUM_GRP-1:0]   grp_flag_r, grp_flag_nxt;
  logic [NUM_GRP-1:0]   grp_en_r, grp_en_nxt;
  logic [NFL-1:0]       prev_r, prev_nxt;
  logic                 wake_r, wake_nxt;
  logic                 cfg_r, cfg_nxt;
  logic                 ack_r, ack_nxt;
  logic [31:0]          rdat_r, rdat_nxt;
  logic                 lv_meta_r;
  logic                 lv_sync_r;
  logic                 cfg_meta_r;
  logic                 cfg_sync_r;
  logic [NUM_SRC-1:0]   hw_set;
  logic [NUM_SRC-1:0]   src_rise;
  logic [NUM_GRP-1:0]   grp_set;
  logic [NUM_GRP-1:0]   grp_req;
  logic [1:0]           sel;
  logic                 entry;
  logic                 stk_full;
  logic [STK_PTR_W-1:0] stk_depth;
  logic                 bus_req;
  logic                 wr_en;
  logic [NFL-1:0]       all_flags;

  assign bus_req = i_wb_cyc && i_wb_stb && !ack_r;
  assign wr_en   = bus_req && i_wb_we && i_wb_sel[0];

  // Detector output is asynchronous to the core clock
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      lv_meta_r <= 1'b0;
      lv_sync_r <= 1'b0;
    end else begin
      lv_meta_r <= i_low_voltage;
      lv_sync_r <= lv_meta_r;
    end
  end

  // Hardware set terms per source
  always_comb begin
    hw_set          = '0;
    hw_set[SRC_EEP] = i_eeprom_write_done;
    hw_set[SRC_LV]  = lv_sync_r;
    for (int t = 0; t < NUM_TM; t++) begin
      hw_set[SRC_TM0 + 2*t]     = i_tm_match_a[t];
      hw_set[SRC_TM0 + 2*t + 1] = i_tm_match_p[t];
    end
  end

  // Per-group request and set terms
  genvar g;
  generate
    for (g = 0; g < NUM_GRP; g++) begin : g_grp
      // Either match flag of a timer feeds its group request
      assign grp_req[g] = grp_flag_r[g] && grp_en_r[g] && gie_r &&
                          !stk_full &&
                          |(src_flag_r & src_en_r & GRP_MEMBER[g]);
      assign grp_set[g] = |(src_rise & GRP_MEMBER[g]);
    end
  endgenerate

  // Fixed priority: lowest group index first
  always_comb begin
    sel = 2'h0;
    for (int i = NUM_GRP - 1; i >= 0; i--) begin
      if (grp_req[i]) begin
        sel = 2'(i);
      end
    end
  end

  assign o_irq_req = |grp_req;
  assign o_irq_vec = sel;
  assign entry     = o_irq_req && i_irq_ack;

  // Flag, enable and global-enable next state
  always_comb begin
    src_flag_nxt = src_flag_r;
    src_en_nxt   = src_en_r;
    grp_flag_nxt = grp_flag_r;
    grp_en_nxt   = grp_en_r;
    gie_nxt      = gie_r;
    if (wr_en) begin
      case (i_wb_adr)
        OFF_CTRL:   gie_nxt      = i_wb_dat[CTRL_GIE_BIT];
        OFF_SRC_FL: src_flag_nxt = i_wb_dat[NUM_SRC-1:0];
        OFF_SRC_EN: src_en_nxt   = i_wb_dat[NUM_SRC-1:0];
        OFF_GRP_FL: grp_flag_nxt = i_wb_dat[NUM_GRP-1:0];
        OFF_GRP_EN: grp_en_nxt   = i_wb_dat[NUM_GRP-1:0];
        default:    gie_nxt      = gie_r;
      endcase
    end
    if (i_irq_return_instr) begin
      gie_nxt = 1'b1;
    end
    if (entry) begin
      gie_nxt           = 1'b0;
      grp_flag_nxt[sel] = 1'b0;
    end
    // Hardware set wins over any clear in the same cycle
    src_flag_nxt = src_flag_nxt | hw_set;
    grp_flag_nxt = grp_flag_nxt | grp_set;
  end

  assign src_rise  = src_flag_nxt & ~src_flag_r;
  assign all_flags = {grp_flag_r, src_flag_r};

  // Wake on any rising flag, enables deliberately ignored
  always_comb begin
    prev_nxt = all_flags;
    wake_nxt = i_sleep && |(all_flags & ~prev_r);
    cfg_nxt  = i_rst ? cfg_sync_r : cfg_r;
  end

  // Bus answer: registered one cycle after the request
  always_comb begin
    ack_nxt  = bus_req;
    rdat_nxt = '0;
    if (bus_req && !i_wb_we) begin
      case (i_wb_adr)
        OFF_CTRL:   rdat_nxt[CTRL_GIE_BIT]   = gie_r;
        OFF_SRC_FL: rdat_nxt[NUM_SRC-1:0]    = src_flag_r;
        OFF_SRC_EN: rdat_nxt[NUM_SRC-1:0]    = src_en_r;
        OFF_GRP_FL: rdat_nxt[NUM_GRP-1:0]    = grp_flag_r;
        OFF_GRP_EN: rdat_nxt[NUM_GRP-1:0]    = grp_en_r;
        OFF_STAT: begin
          rdat_nxt[STAT_CLK_BIT]  = cfg_r;
          rdat_nxt[STAT_FULL_BIT] = stk_full;
          rdat_nxt[STAT_REQ_BIT]  = o_irq_req;
          rdat_nxt[STAT_DEPTH_LSB +: STK_PTR_W] = stk_depth;
        end
        default:    rdat_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      gie_r      <= RST_GIE;
      src_flag_r <= RST_SRC_FL;
      src_en_r   <= RST_SRC_EN;
      grp_flag_r <= RST_GRP_FL;
      grp_en_r   <= RST_GRP_EN;
      prev_r     <= '0;
      wake_r     <= 1'b0;
      ack_r      <= 1'b0;
      rdat_r     <= '0;
    end else begin
      gie_r      <= gie_nxt;
      src_flag_r <= src_flag_nxt;
      src_en_r   <= src_en_nxt;
      grp_flag_r <= grp_flag_nxt;
      grp_en_r   <= grp_en_nxt;
      prev_r     <= prev_nxt;
      wake_r     <= wake_nxt;
      ack_r      <= ack_nxt;
      rdat_r     <= rdat_nxt;
    end
  end

  // Option is sampled only while reset is held, never by software
  // Strap pin is asynchronous; reset outlasts the two sync stages
  always_ff @(posedge i_core_clk) begin
    cfg_meta_r <= i_cfg_clk_mode;
    cfg_sync_r <= cfg_meta_r;
    cfg_r      <= cfg_nxt;
  end

  assign o_wb_ack   = ack_r;
  assign o_wb_dat   = rdat_r;
  assign o_wake     = wake_r;
  assign o_clk_mode = cfg_r;

  // Only the program counter is saved on entry
  giw_pc_stack u_stack (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_push     (entry || i_call),
    .i_pop      (i_ret || i_irq_return_instr),
    .i_pc       (i_pc),
    .o_top_pc   (o_ret_pc),
    .o_full     (stk_full),
    .o_depth    (stk_depth)
  );

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  sequence s_entry;
    entry && !i_irq_return_instr;
  endsequence

  property p_req_gated;
    o_irq_req |-> gie_r && !stk_full && (grp_flag_r & grp_en_r) != '0;
  endproperty
  a_req_gated: assert property (p_req_gated)
    else $error("request raised while gated off");

  property p_entry_clear;
    s_entry |=> !gie_r && (grp_flag_r[$past(sel)] == $past(grp_set[sel]));
  endproperty
  a_entry_clear: assert property (p_entry_clear)
    else $error("entry did not clear enable and group flag");

  property p_src_kept;
    entry && !wr_en |=> (($past(src_flag_r) & ~src_flag_r) == '0);
  endproperty
  a_src_kept: assert property (p_src_kept)
    else $error("source flag lost at entry");

  property p_eep_set;
    i_eeprom_write_done |=> src_flag_r[SRC_EEP];
  endproperty
  a_eep_set: assert property (p_eep_set)
    else $error("eeprom flag not set");

  property p_lv_set;
    $rose(lv_sync_r) |=> src_flag_r[SRC_LV] ##1
      (src_flag_r[SRC_LV] || $past(wr_en));
  endproperty
  a_lv_set: assert property (p_lv_set)
    else $error("low voltage flag not set");

  property p_tm_set;
    i_tm_match_p[0] && !src_flag_r[SRC_TM0 + 1] |=>
      src_flag_r[SRC_TM0 + 1] && grp_flag_r[1];
  endproperty
  a_tm_set: assert property (p_tm_set)
    else $error("timer match did not reach its group");

  property p_wake;
    i_sleep && (all_flags & ~prev_r) != '0 |=> o_wake ##1 !o_wake || i_sleep;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on rising flag");

  property p_irq_return_instr;
    i_irq_return_instr && !entry |=> gie_r;
  endproperty
  a_irq_return_instr: assert property (p_irq_return_instr)
    else $error("interrupt return left enable low");

  property p_ret;
    i_ret && !gie_r && !i_irq_return_instr && !wr_en |=> !gie_r;
  endproperty
  a_ret: assert property (p_ret)
    else $error("plain return set the enable");

  property p_push;
    entry && !i_ret |=> stk_depth == $past(stk_depth) + 4'h1;
  endproperty
  a_push: assert property (p_push)
    else $error("entry did not push one word");

  property p_prio;
    entry && grp_req[0] |-> o_irq_vec == 2'h0 ##1
      (($past(grp_req) & ~grp_flag_r & 3'h6) == 3'h0 || $past(wr_en));
  endproperty
  a_prio: assert property (p_prio)
    else $error("priority order broken");

  property p_cfg;
    !i_rst |=> $stable(cfg_r);
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("clock mode changed outside reset");

endmodule

// ===== sim/giw_cpu_model.sv
// CPU core model: runs a fetch address and takes offered vectors
`timescale 1ns/1ps
module giw_cpu_model (
  // Clock and reset
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst,
  // Bench control
  input  wire logic                     i_en,
  input  wire logic [3:0]               i_dly,
  // Controller side
  input  wire logic                     i_irq_req,
  output logic                          o_irq_ack,
  output logic      [giw_pkg::PC_W-1:0] o_pc,
  output logic      [giw_pkg::PC_W-1:0] o_taken_pc
);
  logic [3:0] wait_r;
  always @(posedge i_core_clk) begin
    o_pc <= i_rst ? '0 : o_pc + 13'h1;
    // Ack is a single pulse; a slow core lets the request wait i_dly cycles
    if (i_rst || !i_en || i_irq_req !== 1'b1 || o_irq_ack) begin
      o_irq_ack <= 1'b0;
      wait_r    <= 4'h0;
    end else if (wait_r >= i_dly) begin
      o_irq_ack  <= 1'b1;
      o_taken_pc <= o_pc + 13'h1;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule

// ===== sim/grouped_interrupt_wakeup_logic_bench.sv
// Self-checking bench for the grouped interrupt and wake-up controller
`timescale 1ns/1ps
module grouped_interrupt_wakeup_logic_bench;
  import giw_pkg::*;
  logic        clk, rst, cyc, stb, we, ack, eep, lv, strap, irq_ack;
  logic        call, ret, irq_return_instr, sleep, req, wake, clk_mode, cpu_en;
  logic [7:0]  adr;
  logic [3:0]  sel, dly;
  logic [31:0] dat, dat_r, q;
  logic [1:0]  tma, tmp, vec;
  logic [12:0] pc, ret_pc, taken_pc;
  logic [5:0]  m;
  int          n_mismatch, checked, n_wake, cyc_cnt, w0;

  giw_irq_ctrl u_dut (
    .i_core_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
    .o_wb_dat(dat_r), .o_wb_ack(ack), .i_eeprom_write_done(eep),
    .i_low_voltage(lv), .i_tm_match_a(tma), .i_tm_match_p(tmp),
    .i_cfg_clk_mode(strap), .i_pc(pc), .i_irq_ack(irq_ack),
    .i_call(call), .i_ret(ret), .i_irq_return_instr(irq_return_instr),
    .i_sleep(sleep), .o_irq_req(req), .o_irq_vec(vec),
    .o_ret_pc(ret_pc), .o_wake(wake), .o_clk_mode(clk_mode));
  giw_cpu_model u_cpu (
    .i_core_clk(clk), .i_rst(rst), .i_en(cpu_en), .i_dly(dly),
    .i_irq_req(req), .o_irq_ack(irq_ack), .o_pc(pc),
    .o_taken_pc(taken_pc));

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc_cnt++;
    if (wake === 1'b1)
      n_wake++;
    if (cyc_cnt == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic fire(input logic [5:0] f);
    @(posedge clk);
    eep <= f[0];
    lv  <= f[1];
    tma <= {f[4], f[2]};
    tmp <= {f[5], f[3]};
    @(posedge clk);
    {eep, lv, tma, tmp} <= 6'h00;
    repeat (4) @(posedge clk);
  endtask
  task automatic cpu_op(input logic [2:0] op);
    @(posedge clk);
    {call, ret, irq_return_instr} <= op;
    @(posedge clk);
    {call, ret, irq_return_instr} <= 3'h0;
    @(posedge clk);
  endtask
  task automatic take();
    int k;
    k = 0;
    while (irq_ack !== 1'b1 && k < 40) begin
      @(posedge clk);
      k++;
    end
    chk("irq taken", 1'b1, irq_ack);
    repeat (2) @(posedge clk);
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk);
    rst   <= 1'b1;
    strap <= s;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  endtask
  function automatic logic [2:0] grp_of(input logic [5:0] f);
    return {|f[5:4], |f[3:2], |f[1:0]};
  endfunction

  initial begin
    {clk, cyc, stb, we, eep, lv, call, ret, irq_return_instr, sleep, cpu_en} = '0;
    {adr, dat, tma, tmp, dly} = '0;
    sel = 4'hf;
    void'($urandom(31351));
    do_reset(1'b1);
    for (int a = 0; a <= 'h18; a += 4)
      rd(a[7:0], (a == 'h14) ? 32'h1 : 32'h0);
    wb(1'b1, 8'h18, 32'h3f);
    rd(8'h18, 32'h0);
    wb(1'b1, OFF_STAT, 32'h0);
    rd(OFF_STAT, 32'h1);
    // A write without the low byte lane must be ignored
    sel <= 4'he;
    wb(1'b1, OFF_CTRL, 32'h1);
    sel <= 4'hf;
    rd(OFF_CTRL, 32'h0);
    $display("reset values done");
    for (int i = 0; i < 10; i++) begin
      m = (i < 6) ? 6'h1 << i : 6'($urandom_range(1, 63));
      fire(m);
      rd(OFF_SRC_FL, m);
      rd(OFF_GRP_FL, grp_of(m));
      wb(1'b1, OFF_SRC_FL, 32'h0);
      wb(1'b1, OFF_GRP_FL, 32'h0);
    end
    $display("event flags done");
    fire(6'h04);
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, OFF_CTRL, c & 1);
      wb(1'b1, OFF_SRC_EN, c[1] ? 32'h04 : 32'h3b);
      wb(1'b1, OFF_GRP_EN, c[2] ? 32'h2 : 32'h5);
      chk("irq request", c == 7, req);
    end
    chk("irq vector", 2'h1, vec);
    wb(1'b1, OFF_GRP_EN, 32'h0);
    rd(OFF_SRC_FL, 32'h04);
    rd(OFF_GRP_FL, 32'h2);
    wb(1'b1, OFF_GRP_EN, 32'h2);
    dly <= 4'($urandom_range(0, 7));
    cpu_en <= 1'b1;
    take();
    rd(OFF_CTRL, 32'h0);
    rd(OFF_GRP_FL, 32'h0);
    rd(OFF_SRC_FL, 32'h04);
    rd(OFF_STAT, 32'h11);
    chk("return pc", taken_pc, ret_pc);
    cpu_op(3'h1);
    rd(OFF_CTRL, 32'h1);
    rd(OFF_STAT, 32'h01);
    $display("gating and entry done");
    wb(1'b1, OFF_CTRL, 32'h0);
    wb(1'b1, OFF_SRC_FL, 32'h0);
    wb(1'b1, OFF_SRC_EN, 32'h3f);
    wb(1'b1, OFF_GRP_EN, 32'h7);
    fire(6'h21);
    cpu_en <= 1'b0;
    wb(1'b1, OFF_CTRL, 32'h1);
    chk("priority vector", 2'h0, vec);
    cpu_en <= 1'b1;
    take();
    rd(OFF_GRP_FL, 32'h4);
    cpu_op(3'h1);
    take();
    rd(OFF_GRP_FL, 32'h0);
    cpu_op(3'h2);
    rd(OFF_CTRL, 32'h0);
    $display("priority and return done");
    wb(1'b1, OFF_SRC_FL, 32'h0);
    wb(1'b1, OFF_GRP_FL, 32'h0);
    wb(1'b1, OFF_GRP_EN, 32'h0);
    @(posedge clk);
    sleep <= 1'b1;
    w0 = n_wake;
    fire(6'h20);
    chk("wake count", w0 + 1, n_wake);
    @(posedge clk);
    sleep <= 1'b0;
    // Preset while awake so the preset itself does not wake the core
    wb(1'b1, OFF_SRC_FL, 32'h20);
    wb(1'b1, OFF_GRP_FL, 32'h4);
    @(posedge clk);
    sleep <= 1'b1;
    w0 = n_wake;
    fire(6'h20);
    chk("masked wake", w0, n_wake);
    fire(6'h10);
    chk("wake count", w0 + 1, n_wake);
    @(posedge clk);
    sleep <= 1'b0;
    $display("wake-up done");
    do_reset(1'b0);
    rd(OFF_STAT, 32'h0);
    chk("clock mode", 1'b0, clk_mode);
    repeat (8) cpu_op(3'h4);
    rd(OFF_STAT, 32'h82);
    wb(1'b1, OFF_SRC_EN, 32'h1);
    wb(1'b1, OFF_GRP_EN, 32'h1);
    wb(1'b1, OFF_CTRL, 32'h1);
    fire(6'h01);
    chk("full stack request", 1'b0, req);
    cpu_op(3'h2);
    chk("request after pop", 1'b1, req);
    $display("stack full done");
    finish_test();
  end
endmodule
